// ### pkg/dtm_pkg.sv
package dtm_pkg;

  // register addresses on the special function register port
  localparam logic [7:0] DTM_ADDR_TIMER_RUN_AND_INT_FLAGS  = 8'h88;
  localparam logic [7:0] DTM_ADDR_TIMER_MODE_CONFIG  = 8'h89;
  localparam logic [7:0] DTM_ADDR_TL0   = 8'h8A;
  localparam logic [7:0] DTM_ADDR_TL1   = 8'h8B;
  localparam logic [7:0] DTM_ADDR_TH0   = 8'h8C;
  localparam logic [7:0] DTM_ADDR_TH1   = 8'h8D;
  localparam logic [7:0] DTM_ADDR_CKCON = 8'h8E;

  // timer_run_and_int_flags bit positions
  localparam int unsigned DTM_TIMER_RUN_AND_INT_FLAGS_TF1 = 7;
  localparam int unsigned DTM_TIMER_RUN_AND_INT_FLAGS_TR1 = 6;
  localparam int unsigned DTM_TIMER_RUN_AND_INT_FLAGS_TF0 = 5;
  localparam int unsigned DTM_TIMER_RUN_AND_INT_FLAGS_TR0 = 4;
  localparam int unsigned DTM_TIMER_RUN_AND_INT_FLAGS_IE1 = 3;
  localparam int unsigned DTM_TIMER_RUN_AND_INT_FLAGS_IT1 = 2;
  localparam int unsigned DTM_TIMER_RUN_AND_INT_FLAGS_IE0 = 1;
  localparam int unsigned DTM_TIMER_RUN_AND_INT_FLAGS_IT0 = 0;

  // timer_mode_config nibbles and clock control rate bits
  localparam int unsigned DTM_TIMER_MODE_CONFIG_T1_LSB = 4;
  localparam int unsigned DTM_TIMER_MODE_CONFIG_T0_LSB = 0;
  localparam int unsigned DTM_CKCON_T1M   = 4;
  localparam int unsigned DTM_CKCON_T0M   = 3;

  // reset values
  localparam logic [7:0] DTM_TIMER_RUN_AND_INT_FLAGS_RST  = 8'h00;
  localparam logic [7:0] DTM_TIMER_MODE_CONFIG_RST  = 8'h00;
  localparam logic [7:0] DTM_COUNT_RST = 8'h00;
  localparam logic       DTM_RATE_RST  = 1'b0;

  // core clock cycles per timer increment
  localparam int unsigned DTM_DIV_FAST = 4;
  localparam int unsigned DTM_DIV_SLOW = 12;

  typedef enum logic [1:0] {
    DTM_MODE_13BIT  = 2'b00,
    DTM_MODE_16BIT  = 2'b01,
    DTM_MODE_RELOAD = 2'b10,
    DTM_MODE_SPLIT  = 2'b11
  } dtm_mode_type;

  typedef struct packed {
    logic         gate;
    logic         ct;
    dtm_mode_type mode;
  } dtm_tmode_type;

  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dtm_sfr_req_type;

  typedef struct packed {
    logic tf1;
    logic tf0;
    logic ie1;
    logic ie0;
  } dtm_flag_type;

endpackage

// ### hw/dtm_prescaler.sv
`timescale 1ns/100ps
module dtm_prescaler #(
  parameter int unsigned DIV_FAST = dtm_pkg::DTM_DIV_FAST,
  parameter int unsigned DIV_SLOW = dtm_pkg::DTM_DIV_SLOW
) (
  // clock and reset
  input  wire logic mclk,
  input  wire logic resetn,
  input  wire logic clk_en,
  // increment strobes
  output logic      tick_fast,
  output logic      tick_slow
);
  import dtm_pkg::*;

  localparam int unsigned CW = $clog2(DIV_SLOW);

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  // spacing counter kept apart from cnt_q so the check does not judge itself
  logic [CW-1:0] gap_q;
  logic [CW-1:0] gap_d;

  // one shared counter keeps both rates phase aligned
  always_comb begin
    tick_slow = (cnt_q == CW'(DIV_SLOW - 1));
    tick_fast = (CW'(cnt_q % CW'(DIV_FAST)) == CW'(DIV_FAST - 1));
    cnt_d     = tick_slow ? '0 : cnt_q + 1'b1;
    gap_d     = tick_slow ? '0 : gap_q + 1'b1;
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= '0;
      gap_q <= '0;
    end else if (clk_en) begin
      cnt_q <= cnt_d;
      gap_q <= gap_d;
    end
  end

  chk_slow_spacing: assert property (
    @(posedge mclk) disable iff (!resetn)
    clk_en |-> (tick_slow == (gap_q == CW'(DIV_SLOW - 1))))
    else $error("slow tick spacing not twelve cycles");

endmodule

// ### hw/dtm_pin_sync.sv
`timescale 1ns/100ps
module dtm_pin_sync #(
  parameter int unsigned W = 4
) (
  // clock and reset
  input  wire logic         mclk,
  input  wire logic         resetn,
  input  wire logic         clk_en,
  // raw pins and conditioned views
  input  wire logic [W-1:0] pins,
  output logic      [W-1:0] level,
  output logic      [W-1:0] fall
);
  import dtm_pkg::*;

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  // stages start high so release of reset with the pins idle high never looks like an edge
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s1_q <= '1;
      s2_q <= '1;
      s3_q <= '1;
    end else if (clk_en) begin
      s1_q <= pins;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  always_comb begin
    level = s2_q;
    fall  = s3_q & ~s2_q;
  end

endmodule

// ### hw/dtm_timer_core.sv
`timescale 1ns/100ps
module dtm_timer_core (
  // clock and reset
  input  wire logic                     mclk,
  input  wire logic                     resetn,
  input  wire logic                     clk_en,
  // special function register port
  input  wire dtm_pkg::dtm_sfr_req_type sfr_req,
  output logic                    [7:0] sfr_rdata,
  // vectoring acknowledges from the interrupt controller
  input  wire dtm_pkg::dtm_flag_type    vec_ack,
  // external pins
  input  wire logic                     ext_irq_pin_a_n,
  input  wire logic                     ext_irq_pin_b_n,
  input  wire logic                     first_timer_event_pin,
  input  wire logic                     second_timer_event_pin,
  // requests and serial clocking
  output dtm_pkg::dtm_flag_type         irq_flags,
  output logic                          baud_tick
);
  import dtm_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  logic [7:0]    timer_run_and_int_flags_q, timer_run_and_int_flags_d;
  logic [7:0]    timer_mode_config_q, timer_mode_config_d;
  logic          t0m_q, t0m_d;
  logic          t1m_q, t1m_d;
  logic [7:0]    tl0_q, tl0_d;
  logic [7:0]    th0_q, th0_d;
  logic [7:0]    tl1_q, tl1_d;
  logic [7:0]    th1_q, th1_d;
  logic [7:0]    rdata_q, rdata_d;
  logic          baud_q, baud_d;
  logic          tick_fast;
  logic          tick_slow;
  logic [3:0]    pin_lvl;
  logic [3:0]    pin_fall;
  dtm_tmode_type tm0;
  dtm_tmode_type tm1;
  logic          split0;
  logic          t0_tick, t0_ovf;
  logic          th0_tick, th0_ovf;
  logic          t1_run, t1_tick, t1_ovf;
  logic          tf0_set, tf1_set;
  logic [16:0]   t0_step, t1_step;
  logic          wr_timer_run_and_int_flags, wr_timer_mode_config, wr_ckcon;
  logic          wr_tl0, wr_th0, wr_tl1, wr_th1;

  ////////////////////////////////////////////////////////////////////////
  function automatic logic count_en(logic run, logic gate, logic pin_hi);
    return run & (~gate | pin_hi);
  endfunction

  function automatic logic src_tick(logic ct, logic fast, logic ev,
                                    logic tf, logic ts);
    return ct ? ev : (fast ? tf : ts);
  endfunction

  // result is {overflow, high byte, low byte}
  function automatic logic [16:0] step(dtm_mode_type m, logic [7:0] tl,
                                       logic [7:0] th);
    logic [13:0] c13;
    logic [16:0] c16;
    logic [8:0]  c8;
    logic [16:0] r;
    c13 = {1'b0, th, tl[4:0]} + 14'h0001;
    c16 = {1'b0, th, tl} + 17'h00001;
    c8  = {1'b0, tl} + 9'h001;
    case (m)
      DTM_MODE_13BIT: begin
        r = {c13[13], c13[12:5], tl[7:5], c13[4:0]};
      end
      DTM_MODE_16BIT: begin
        r = c16;
      end
      DTM_MODE_RELOAD: begin
        r = {c8[8], th, (c8[8] ? th : c8[7:0])};
      end
      DTM_MODE_SPLIT: begin
        r = {c8[8], th, c8[7:0]};
      end
      default: begin
        r = {1'b0, th, tl};
      end
    endcase
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  dtm_prescaler u_prescaler (
    .mclk      (mclk),
    .resetn    (resetn),
    .clk_en    (clk_en),
    .tick_fast (tick_fast),
    .tick_slow (tick_slow)
  );

  // bit order: event b, event a, irq b, irq a
  dtm_pin_sync #(.W(4)) u_pin_sync (
    .mclk   (mclk),
    .resetn (resetn),
    .clk_en (clk_en),
    .pins   ({second_timer_event_pin, first_timer_event_pin,
              ext_irq_pin_b_n, ext_irq_pin_a_n}),
    .level  (pin_lvl),
    .fall   (pin_fall)
  );

  ////////////////////////////////////////////////////////////////////////
  // register port decode
  always_comb begin
    wr_timer_run_and_int_flags  = sfr_req.wr && (sfr_req.addr == DTM_ADDR_TIMER_RUN_AND_INT_FLAGS);
    wr_timer_mode_config  = sfr_req.wr && (sfr_req.addr == DTM_ADDR_TIMER_MODE_CONFIG);
    wr_ckcon = sfr_req.wr && (sfr_req.addr == DTM_ADDR_CKCON);
    wr_tl0   = sfr_req.wr && (sfr_req.addr == DTM_ADDR_TL0);
    wr_th0   = sfr_req.wr && (sfr_req.addr == DTM_ADDR_TH0);
    wr_tl1   = sfr_req.wr && (sfr_req.addr == DTM_ADDR_TL1);
    wr_th1   = sfr_req.wr && (sfr_req.addr == DTM_ADDR_TH1);
  end

  ////////////////////////////////////////////////////////////////////////
  // counters
  always_comb begin
    tm0      = dtm_tmode_type'(timer_mode_config_q[DTM_TIMER_MODE_CONFIG_T0_LSB +: 4]);
    tm1      = dtm_tmode_type'(timer_mode_config_q[DTM_TIMER_MODE_CONFIG_T1_LSB +: 4]);
    split0   = (tm0.mode == DTM_MODE_SPLIT);
    t0_tick  = count_en(timer_run_and_int_flags_q[DTM_TIMER_RUN_AND_INT_FLAGS_TR0], tm0.gate, pin_lvl[0]) &
               src_tick(tm0.ct, t0m_q, pin_fall[2],
                        tick_fast, tick_slow);
    t0_step  = step(tm0.mode, tl0_q, th0_q);
    t0_ovf   = t0_tick & t0_step[16];
    // high half never sees the event pin
    th0_tick = split0 & timer_run_and_int_flags_q[DTM_TIMER_RUN_AND_INT_FLAGS_TR1] &
               (t0m_q ? tick_fast : tick_slow);
    th0_ovf  = th0_tick & (th0_q == 8'hFF);
    // with the first timer split the mode field takes the place of the second run bit as on/off
    t1_run   = split0 ? (tm1.mode != DTM_MODE_SPLIT)
                      : timer_run_and_int_flags_q[DTM_TIMER_RUN_AND_INT_FLAGS_TR1];
    t1_tick  = (tm1.mode != DTM_MODE_SPLIT) &
               count_en(t1_run, tm1.gate, pin_lvl[1]) &
               src_tick(tm1.ct, t1m_q, pin_fall[3],
                        tick_fast, tick_slow);
    t1_step  = step(tm1.mode, tl1_q, th1_q);
    t1_ovf   = t1_tick & t1_step[16];
    tf0_set  = t0_ovf;
    tf1_set  = split0 ? th0_ovf : t1_ovf;
    baud_d   = t1_ovf;
    tl0_d    = tl0_q;
    th0_d    = th0_q;
    tl1_d    = tl1_q;
    th1_d    = th1_q;
    if (t0_tick) begin
      {th0_d, tl0_d} = t0_step[15:0];
    end
    if (th0_tick) begin
      th0_d = th0_q + 8'h01;
    end
    if (t1_tick) begin
      {th1_d, tl1_d} = t1_step[15:0];
    end
    // software load takes priority over a same-cycle increment
    if (wr_tl0) begin
      tl0_d = sfr_req.wdata;
    end
    if (wr_th0) begin
      th0_d = sfr_req.wdata;
    end
    if (wr_tl1) begin
      tl1_d = sfr_req.wdata;
    end
    if (wr_th1) begin
      th1_d = sfr_req.wdata;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      tl0_q  <= DTM_COUNT_RST;
      th0_q  <= DTM_COUNT_RST;
      tl1_q  <= DTM_COUNT_RST;
      th1_q  <= DTM_COUNT_RST;
      baud_q <= 1'b0;
    end else if (clk_en) begin
      tl0_q  <= tl0_d;
      th0_q  <= th0_d;
      tl1_q  <= tl1_d;
      th1_q  <= th1_d;
      baud_q <= baud_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control and flags; hardware set wins over any clear
  always_comb begin
    timer_run_and_int_flags_d = timer_run_and_int_flags_q;
    timer_mode_config_d = wr_timer_mode_config ? sfr_req.wdata : timer_mode_config_q;
    t0m_d  = wr_ckcon ? sfr_req.wdata[DTM_CKCON_T0M] : t0m_q;
    t1m_d  = wr_ckcon ? sfr_req.wdata[DTM_CKCON_T1M] : t1m_q;
    if (wr_timer_run_and_int_flags) begin
      timer_run_and_int_flags_d = sfr_req.wdata;
    end
    timer_run_and_int_flags_d[DTM_TIMER_RUN_AND_INT_FLAGS_TF1] = tf1_set |
      (wr_timer_run_and_int_flags ? sfr_req.wdata[DTM_TIMER_RUN_AND_INT_FLAGS_TF1]
               : timer_run_and_int_flags_q[DTM_TIMER_RUN_AND_INT_FLAGS_TF1] & ~vec_ack.tf1);
    timer_run_and_int_flags_d[DTM_TIMER_RUN_AND_INT_FLAGS_TF0] = tf0_set |
      (wr_timer_run_and_int_flags ? sfr_req.wdata[DTM_TIMER_RUN_AND_INT_FLAGS_TF0]
               : timer_run_and_int_flags_q[DTM_TIMER_RUN_AND_INT_FLAGS_TF0] & ~vec_ack.tf0);
    if (timer_run_and_int_flags_q[DTM_TIMER_RUN_AND_INT_FLAGS_IT1]) begin
      timer_run_and_int_flags_d[DTM_TIMER_RUN_AND_INT_FLAGS_IE1] = pin_fall[1] |
        (wr_timer_run_and_int_flags ? sfr_req.wdata[DTM_TIMER_RUN_AND_INT_FLAGS_IE1]
                 : timer_run_and_int_flags_q[DTM_TIMER_RUN_AND_INT_FLAGS_IE1] & ~vec_ack.ie1);
    end else begin
      timer_run_and_int_flags_d[DTM_TIMER_RUN_AND_INT_FLAGS_IE1] = ~pin_lvl[1];
    end
    if (timer_run_and_int_flags_q[DTM_TIMER_RUN_AND_INT_FLAGS_IT0]) begin
      timer_run_and_int_flags_d[DTM_TIMER_RUN_AND_INT_FLAGS_IE0] = pin_fall[0] |
        (wr_timer_run_and_int_flags ? sfr_req.wdata[DTM_TIMER_RUN_AND_INT_FLAGS_IE0]
                 : timer_run_and_int_flags_q[DTM_TIMER_RUN_AND_INT_FLAGS_IE0] & ~vec_ack.ie0);
    end else begin
      timer_run_and_int_flags_d[DTM_TIMER_RUN_AND_INT_FLAGS_IE0] = ~pin_lvl[0];
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      timer_run_and_int_flags_q <= DTM_TIMER_RUN_AND_INT_FLAGS_RST;
      timer_mode_config_q <= DTM_TIMER_MODE_CONFIG_RST;
      t0m_q  <= DTM_RATE_RST;
      t1m_q  <= DTM_RATE_RST;
    end else if (clk_en) begin
      timer_run_and_int_flags_q <= timer_run_and_int_flags_d;
      timer_mode_config_q <= timer_mode_config_d;
      t0m_q  <= t0m_d;
      t1m_q  <= t1m_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read data registered every enabled cycle
  always_comb begin
    case (sfr_req.addr)
      DTM_ADDR_TIMER_RUN_AND_INT_FLAGS: begin
        rdata_d = timer_run_and_int_flags_q;
      end
      DTM_ADDR_TIMER_MODE_CONFIG: begin
        rdata_d = timer_mode_config_q;
      end
      DTM_ADDR_TL0: begin
        rdata_d = tl0_q;
      end
      DTM_ADDR_TH0: begin
        rdata_d = th0_q;
      end
      DTM_ADDR_TL1: begin
        rdata_d = tl1_q;
      end
      DTM_ADDR_TH1: begin
        rdata_d = th1_q;
      end
      DTM_ADDR_CKCON: begin
        rdata_d = 8'h00;
        rdata_d[DTM_CKCON_T1M] = t1m_q;
        rdata_d[DTM_CKCON_T0M] = t0m_q;
      end
      default: begin
        rdata_d = 8'h00;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= 8'h00;
    end else if (clk_en) begin
      rdata_q <= rdata_d;
    end
  end

  always_comb begin
    sfr_rdata = rdata_q;
    baud_tick = baud_q;
    irq_flags = {timer_run_and_int_flags_q[DTM_TIMER_RUN_AND_INT_FLAGS_TF1], timer_run_and_int_flags_q[DTM_TIMER_RUN_AND_INT_FLAGS_TF0],
                 timer_run_and_int_flags_q[DTM_TIMER_RUN_AND_INT_FLAGS_IE1], timer_run_and_int_flags_q[DTM_TIMER_RUN_AND_INT_FLAGS_IE0]};
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking dtm_cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  chk_tf0_on_ovf: assert property (
    clk_en && t0_ovf |=> irq_flags.tf0)
    else $error("first overflow flag missed an overflow");

  chk_tf1_vec_clear: assert property (
    clk_en && vec_ack.tf1 && !tf1_set && !wr_timer_run_and_int_flags |=> !irq_flags.tf1)
    else $error("second overflow flag not cleared on vectoring");

  chk_run_stops_t0: assert property (
    clk_en && !timer_run_and_int_flags_q[DTM_TIMER_RUN_AND_INT_FLAGS_TR0] && !wr_tl0 |=> $stable(tl0_q))
    else $error("first timer low byte moved without run bit");

  chk_edge_ie0: assert property (
    clk_en && timer_run_and_int_flags_q[DTM_TIMER_RUN_AND_INT_FLAGS_IT0] && pin_fall[0] |=> irq_flags.ie0)
    else $error("falling edge did not set request a");

  chk_level_ie1: assert property (
    clk_en && !timer_run_and_int_flags_q[DTM_TIMER_RUN_AND_INT_FLAGS_IT1] |=> irq_flags.ie1 == !$past(pin_lvl[1]))
    else $error("level request b does not follow pin");

  chk_reload_value: assert property (
    clk_en && tm0.mode == DTM_MODE_RELOAD && t0_tick && tl0_q == 8'hFF
      && !wr_tl0 && !wr_th0 |=> tl0_q == $past(th0_q) && irq_flags.tf0)
    else $error("reload did not copy high byte");

  chk_split_high_run: assert property (
    clk_en && split0 && !timer_run_and_int_flags_q[DTM_TIMER_RUN_AND_INT_FLAGS_TR1] && !wr_th0 |=> $stable(th0_q))
    else $error("split high byte counted without second run bit");

  chk_second_parked: assert property (
    clk_en && tm1.mode == DTM_MODE_SPLIT && !wr_tl1 && !wr_th1
      |=> $stable({th1_q, tl1_q}))
    else $error("second timer counted in mode 3");

  chk_gate_blocks: assert property (
    clk_en && tm0.gate && !pin_lvl[0] && !wr_tl0 |=> $stable(tl0_q))
    else $error("gated first timer counted with pin low");

  cov_split_ovf:  cover property (clk_en && th0_ovf);
  cov_reload:     cover property (clk_en && t0_ovf && tm0.mode == DTM_MODE_RELOAD);
  cov_edge_b:     cover property (clk_en && timer_run_and_int_flags_q[DTM_TIMER_RUN_AND_INT_FLAGS_IT1] && pin_fall[1]);
  cov_baud_split: cover property (clk_en && split0 && t1_ovf);

endmodule

// ### tb/dtm_pin_partner.sv
`timescale 1ns/100ps
module dtm_pin_partner (
  // clock
  input  wire logic mclk,
  // pins toward the timer block
  output logic      ext_irq_pin_a_n,
  output logic      ext_irq_pin_b_n,
  output logic      first_timer_event_pin,
  output logic      second_timer_event_pin
);
  initial begin
    ext_irq_pin_a_n        = 1'b1;
    ext_irq_pin_b_n        = 1'b1;
    first_timer_event_pin  = 1'b1;
    second_timer_event_pin = 1'b1;
  end

  task automatic set_irq(input int idx, input logic lvl);
    @(posedge mclk);
    if (idx == 0) ext_irq_pin_a_n <= lvl;
    else ext_irq_pin_b_n <= lvl;
  endtask

  // low phases of three cycles and high phases of four so the synchroniser sees each one
  task automatic pulse_event(input int idx, input int n);
    for (int k = 0; k < n; k++) begin
      @(posedge mclk);
      if (idx == 0) first_timer_event_pin <= 1'b0;
      else second_timer_event_pin <= 1'b0;
      repeat (3) @(posedge mclk);
      if (idx == 0) first_timer_event_pin <= 1'b1;
      else second_timer_event_pin <= 1'b1;
      repeat (3) @(posedge mclk);
    end
  endtask
endmodule

// ### tb/testbench.sv
`timescale 1ns/100ps
module testbench;
  import dtm_pkg::*;
  logic            mclk;
  logic            resetn;
  logic            clk_en;
  dtm_sfr_req_type sfr_req;
  logic [7:0]      sfr_rdata;
  dtm_flag_type    vec_ack;
  dtm_flag_type    irq_flags;
  logic            baud_tick;
  wire logic       pin_a_n;
  wire logic       pin_b_n;
  wire logic       ev0;
  wire logic       ev1;
  wire logic [3:0] fl;
  int              miscompares;
  int              n_compared;
  int              n;
  logic [7:0]      a;
  logic [7:0]      b;

  assign fl = irq_flags;

  dtm_timer_core i_dut (
    .mclk(mclk), .resetn(resetn), .clk_en(clk_en), .sfr_req(sfr_req),
    .sfr_rdata(sfr_rdata), .vec_ack(vec_ack), .ext_irq_pin_a_n(pin_a_n),
    .ext_irq_pin_b_n(pin_b_n), .first_timer_event_pin(ev0),
    .second_timer_event_pin(ev1), .irq_flags(irq_flags), .baud_tick(baud_tick)
  );

  dtm_pin_partner i_partner (
    .mclk(mclk), .ext_irq_pin_a_n(pin_a_n), .ext_irq_pin_b_n(pin_b_n),
    .first_timer_event_pin(ev0), .second_timer_event_pin(ev1)
  );

  initial begin
    mclk        = 1'b0;
    resetn      = 1'b0;
    clk_en      = 1'b1;
    sfr_req     = '0;
    vec_ack     = '0;
    miscompares = 0;
    n_compared  = 0;
  end

  always #12.5 mclk = ~mclk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", name, exp, got);
      miscompares++;
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask

  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(posedge mclk);
    sfr_req <= '{wr: 1'b1, addr: ad, wdata: d};
    @(posedge mclk);
    sfr_req.wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] ad, output logic [7:0] d);
    @(posedge mclk);
    sfr_req <= '{wr: 1'b0, addr: ad, wdata: 8'h00};
    @(posedge mclk);
    #1;
    d = sfr_rdata;
  endtask

  task automatic rd_chk(input string name, input logic [7:0] ad, input logic [7:0] e);
    logic [7:0] d;
    rd(ad, d);
    chk(name, e, d);
  endtask

  task automatic ack(input logic [3:0] m);
    @(posedge mclk);
    vec_ack <= m;
    @(posedge mclk);
    vec_ack <= '0;
    #1;
  endtask

  // bounded wait on one flag bit, cycle count returned
  task automatic wait_flag(input int bn, input int lim, output int k);
    k = 0;
    while (fl[bn] !== 1'b1) begin
      if (k >= lim) begin
        $display("Error flag %0d wait expected 1 seen %b", bn, fl[bn]);
        miscompares++;
        wrap_up();
      end
      cyc(1);
      k++;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_edge;
    logic [7:0] it;
    for (int i = 0; i < 2; i++) begin
      it = (i == 0) ? 8'h01 : 8'h04;
      wr(DTM_ADDR_TIMER_RUN_AND_INT_FLAGS, it);
      i_partner.set_irq(i, 1'b0);
      cyc(6);
      chk("edge set", 8'h01, {7'h00, fl[i]});
      i_partner.set_irq(i, 1'b1);
      cyc(6);
      chk("edge held", 8'h01, {7'h00, fl[i]});
      ack(4'h1 << i);
      cyc(1);
      chk("vector clear", 8'h00, {7'h00, fl[i]});
      i_partner.set_irq(i, 1'b0);
      i_partner.set_irq(i, 1'b1);
      cyc(6);
      wr(DTM_ADDR_TIMER_RUN_AND_INT_FLAGS, it);
      rd_chk("soft clear", DTM_ADDR_TIMER_RUN_AND_INT_FLAGS, it);
    end
  endtask

  task automatic t_level;
    wr(DTM_ADDR_TIMER_RUN_AND_INT_FLAGS, 8'h00);
    for (int i = 0; i < 2; i++) begin
      i_partner.set_irq(i, 1'b0);
      cyc(5);
      wr(DTM_ADDR_TIMER_RUN_AND_INT_FLAGS, 8'h00);
      chk("level low", 8'h01, {7'h00, fl[i]});
      i_partner.set_irq(i, 1'b1);
      cyc(5);
      wr(DTM_ADDR_TIMER_RUN_AND_INT_FLAGS, (i == 0) ? 8'h02 : 8'h08);
      cyc(1);
      chk("level high", 8'h00, {7'h00, fl[i]});
    end
  endtask

  task automatic t_reload;
    wr(DTM_ADDR_CKCON, 8'h08);
    wr(DTM_ADDR_TIMER_MODE_CONFIG, 8'h02);
    wr(DTM_ADDR_TH0, 8'hF0);
    wr(DTM_ADDR_TL0, 8'hFE);
    wr(DTM_ADDR_TIMER_RUN_AND_INT_FLAGS, 8'h10);
    wait_flag(2, 50, n);
    wr(DTM_ADDR_TIMER_RUN_AND_INT_FLAGS, 8'h00);
    chk("fast gap", 8'h01, {7'h00, n >= 3 && n <= 8});
    rd_chk("reload low", DTM_ADDR_TL0, 8'hF0);
    rd_chk("reload high", DTM_ADDR_TH0, 8'hF0);
    cyc(20);
    rd_chk("stopped low", DTM_ADDR_TL0, 8'hF0);
    ack(4'h4);
    chk("tf0 clear", 8'h00, {7'h00, fl[2]});
    wr(DTM_ADDR_CKCON, 8'h00);
    wr(DTM_ADDR_TL0, 8'hFD);
    wr(DTM_ADDR_TIMER_RUN_AND_INT_FLAGS, 8'h10);
    wait_flag(2, 60, n);
    wr(DTM_ADDR_TIMER_RUN_AND_INT_FLAGS, 8'h00);
    chk("slow gap", 8'h01, {7'h00, n >= 23 && n <= 36});
    ack(4'h4);
  endtask

  task automatic t_wide;
    wr(DTM_ADDR_TIMER_MODE_CONFIG, 8'h01);
    wr(DTM_ADDR_CKCON, 8'h08);
    wr(DTM_ADDR_TH0, 8'hFF);
    wr(DTM_ADDR_TL0, 8'hFE);
    wr(DTM_ADDR_TIMER_RUN_AND_INT_FLAGS, 8'h10);
    wait_flag(2, 50, n);
    wr(DTM_ADDR_TIMER_RUN_AND_INT_FLAGS, 8'h00);
    rd_chk("wide low", DTM_ADDR_TL0, 8'h00);
    rd_chk("wide high", DTM_ADDR_TH0, 8'h00);
    ack(4'h4);
    @(posedge mclk);
    clk_en <= 1'b0;
    wr(DTM_ADDR_TL0, 8'h55);
    @(posedge mclk);
    clk_en <= 1'b1;
    rd_chk("frozen write", DTM_ADDR_TL0, 8'h00);
  endtask

  task automatic t_split;
    wr(DTM_ADDR_CKCON, 8'h08);
    wr(DTM_ADDR_TH1, 8'hFF);
    wr(DTM_ADDR_TL1, 8'h1E);
    wr(DTM_ADDR_TIMER_MODE_CONFIG, 8'h03);
    n = 0;
    while (baud_tick !== 1'b1 && n < 60) begin
      cyc(1);
      n++;
    end
    chk("split baud", 8'h01, {7'h00, baud_tick});
    chk("split tf1", 8'h00, {7'h00, fl[3]});
    wr(DTM_ADDR_TH0, 8'hFF);
    wr(DTM_ADDR_TL0, 8'h20);
    wr(DTM_ADDR_TIMER_RUN_AND_INT_FLAGS, 8'h40);
    wait_flag(3, 40, n);
    wr(DTM_ADDR_TIMER_RUN_AND_INT_FLAGS, 8'h00);
    rd_chk("split high", DTM_ADDR_TH0, 8'h00);
    rd_chk("split low", DTM_ADDR_TL0, 8'h20);
    ack(4'h8);
    chk("tf1 clear", 8'h00, {7'h00, fl[3]});
    rd(DTM_ADDR_TL1, a);
    cyc(30);
    rd(DTM_ADDR_TL1, b);
    chk("second runs", 8'h01, {7'h00, a !== b});
    wr(DTM_ADDR_TIMER_MODE_CONFIG, 8'h33);
    rd(DTM_ADDR_TL1, a);
    cyc(30);
    rd_chk("second parked", DTM_ADDR_TL1, a);
  endtask

  task automatic t_gate;
    wr(DTM_ADDR_TIMER_MODE_CONFIG, 8'h0E);
    wr(DTM_ADDR_TH0, 8'h00);
    wr(DTM_ADDR_TL0, 8'h10);
    wr(DTM_ADDR_TIMER_RUN_AND_INT_FLAGS, 8'h10);
    i_partner.pulse_event(0, 3);
    cyc(4);
    rd_chk("event count", DTM_ADDR_TL0, 8'h13);
    i_partner.set_irq(0, 1'b0);
    cyc(4);
    i_partner.pulse_event(0, 2);
    cyc(4);
    rd_chk("gated", DTM_ADDR_TL0, 8'h13);
    i_partner.set_irq(0, 1'b1);
    cyc(4);
    i_partner.pulse_event(0, 1);
    cyc(4);
    rd_chk("ungated", DTM_ADDR_TL0, 8'h14);
    wr(DTM_ADDR_TIMER_MODE_CONFIG, 8'h43);
    wr(DTM_ADDR_TL1, 8'h00);
    i_partner.pulse_event(1, 2);
    cyc(4);
    rd_chk("second events", DTM_ADDR_TL1, 8'h02);
    wr(DTM_ADDR_TIMER_MODE_CONFIG, 8'hC3);
    i_partner.set_irq(1, 1'b0);
    cyc(4);
    i_partner.pulse_event(1, 2);
    cyc(4);
    rd_chk("second gated", DTM_ADDR_TL1, 8'h02);
    i_partner.set_irq(1, 1'b1);
    cyc(4);
    i_partner.pulse_event(1, 1);
    cyc(4);
    rd_chk("second ungated", DTM_ADDR_TL1, 8'h03);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge mclk);
    resetn <= 1'b1;
    cyc(1);
    rd_chk("reset timer_run_and_int_flags", DTM_ADDR_TIMER_RUN_AND_INT_FLAGS, 8'h00);
    t_edge();
    t_level();
    t_reload();
    t_wide();
    t_split();
    t_gate();
    wrap_up();
  end
endmodule
